// File: sim/abu_chk.sv
// Checker for the breakpoint unit's link signals.
// Assumes one clock, synchronous low reset, and the design's registered outputs.
`timescale 1ns/1ps
`include "abu_cfg.svh"
module abu_chk (
	// Clock and reset
	input wire logic                  sys_clk_i,
	input wire logic                  rst_b_i,
	// Link signals
	input wire logic                  fetch_valid,
	input wire logic                  break_state,
	input wire logic                  test_voltage,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire abu_pkg::abu_reg_type  reg_addr,
	input wire abu_pkg::abu_byte_type reg_wdata,
	input wire abu_pkg::abu_byte_type reg_rdata,
	input wire logic                  break_req,
	input wire logic                  timer_stop,
	input wire logic                  watchdog_off,
	input wire logic                  flag_clear_en
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Forced break: software writes the active bit outside a break
	sequence s_force;
		reg_wr && reg_addr == `ABU_OFF_SCR && reg_wdata[`ABU_BIT_ACTIVE] && !break_state;
	endsequence
	sequence s_req;
		##1 break_req;
	endsequence
	property p_force; s_force |-> s_req; endproperty
	a_force: assert property (p_force) else $error("forced break not requested");
	// Request must not drop before the host enters the break
	property p_hold; break_req && !break_state |=> break_req; endproperty
	a_hold: assert property (p_hold) else $error("break request dropped early");
	// A request only rises after a fetch or a register write
	property p_cause; $rose(break_req) |-> $past(fetch_valid || reg_wr); endproperty
	a_cause: assert property (p_cause) else $error("break request without cause");
	property p_timer; timer_stop == $past(break_state); endproperty
	a_timer: assert property (p_timer) else $error("timer stop wrong");
	property p_wdog; watchdog_off == $past(break_state && test_voltage); endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog disable wrong");
	property p_flag; $past(rst_b_i) && !$past(break_state) |-> flag_clear_en; endproperty
	a_flag: assert property (p_flag) else $error("flag clear blocked outside break");
	// Read data stands only in the cycle after a read
	property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read");
	property p_unmap; reg_rd && reg_addr > `ABU_OFF_FCTL |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // abu_chk

// File: sim/testbench.sv
// Bench joining both ends of the breakpoint unit, with a small reference model.
// Assumes a 100 MHz clock and the register offsets of abu_cfg.svh.
`timescale 1ns/1ps
`include "abu_cfg.svh"
module testbench;
	logic        sys_clk_i, rst_b_i, emu, fv, opc, iend, inw, tv, dwr, drd, swr, srd, sint, irq;
	logic [2:0]  da;
	logic [1:0]  sa;
	logic [7:0]  dwd, drdo, swd, srdo;
	logic [15:0] fa, vec, ma;
	int          n_mismatch, n_tests, n_sint, m_act;
	logic [15:0] exp_vec[$];
	abu_if lnk_if();
	abu_device abu_device_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
		.emulation_mode_i(emu), .lnk(lnk_if));
	abu_host abu_host_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .fetch_valid_i(fv),
		.fetch_addr_i(fa), .opcode_cycle_i(opc), .insn_end_i(iend), .in_wait_i(inw), .test_voltage_i(tv),
		.dev_wr_i(dwr), .dev_rd_i(drd), .dev_addr_i(da), .dev_wdata_i(dwd), .dev_rdata_o(drdo),
		.sw_addr_i(sa), .sw_wdata_i(swd), .sw_wr_i(swr), .sw_rd_i(srd), .sw_rdata_o(srdo),
		.soft_int_load_o(sint), .vector_o(vec), .irq_o(irq), .lnk(lnk_if));
	abu_chk abu_chk_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .fetch_valid(lnk_if.fetch_valid),
		.break_state(lnk_if.break_state), .test_voltage(lnk_if.test_voltage), .reg_wr(lnk_if.reg_wr),
		.reg_rd(lnk_if.reg_rd), .reg_addr(lnk_if.reg_addr), .reg_wdata(lnk_if.reg_wdata),
		.reg_rdata(lnk_if.reg_rdata), .break_req(lnk_if.break_req), .timer_stop(lnk_if.timer_stop),
		.watchdog_off(lnk_if.watchdog_off), .flag_clear_en(lnk_if.flag_clear_en));
	// Free-running clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Count break loads so a double pulse is caught
	always @(posedge sys_clk_i) if (sint === 1'b1) n_sint++;
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task st;
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask
	task dw(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		dwr <= 1'b1;
		da <= a;
		dwd <= d;
		@(posedge sys_clk_i);
		dwr <= 1'b0;
	endtask
	task dr(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		drd <= 1'b1;
		da <= a;
		@(posedge sys_clk_i);
		drd <= 1'b0;
		#1 chk(lnk_if.reg_rdata, e);
		@(posedge sys_clk_i);
		#1 chk(drdo, e);
	endtask
	task sw(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		swr <= 1'b1;
		sa <= a;
		swd <= d;
		@(posedge sys_clk_i);
		swr <= 1'b0;
	endtask
	task sr(input logic [1:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		srd <= 1'b1;
		sa <= a;
		@(posedge sys_clk_i);
		srd <= 1'b0;
		#1 chk(srdo, e);
	endtask
	// One fetch cycle, then time for the request to register
	task fe(input logic [15:0] a);
		@(posedge sys_clk_i);
		fv <= 1'b1;
		opc <= 1'b1;
		fa <= a;
		@(posedge sys_clk_i);
		fv <= 1'b0;
		st;
	endtask
	// Instruction boundary: the host takes a pending break here
	task ie;
		@(posedge sys_clk_i);
		iend <= 1'b1;
		@(posedge sys_clk_i);
		iend <= 1'b0;
		st;
		chk(lnk_if.break_state, 1'b1);
		chk(vec, exp_vec.pop_front());
		chk(lnk_if.timer_stop, 1'b1);
	endtask
	// Clear the active bit, then return from the break routine
	task ret;
		dw(`ABU_OFF_SCR, 8'h80);
		m_act = 0;
		sw(`ABU_COFF_CTRL, 8'h02);
		st;
		chk(lnk_if.break_state, 1'b0);
		chk(lnk_if.timer_stop, 1'b0);
	endtask
	task give_verdict;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Hang guard, far beyond the sequence length
	initial begin
		#200000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		{rst_b_i, emu, fv, opc, iend, inw, tv, dwr, drd, swr, srd} = '0;
		{da, sa, dwd, swd, fa} = '0;
		void'($urandom(29));
		repeat (3) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 6; i++) dr(i[2:0], 8'h00);
		ma = 16'($urandom());
		dw(`ABU_OFF_ADRH, ma[15:8]);
		dw(`ABU_OFF_ADRL, ma[7:0]);
		fe(ma);
		chk(lnk_if.break_req, 1'b0);
		dw(`ABU_OFF_SCR, 8'h80);
		fe(ma ^ 16'h0001);
		chk(lnk_if.break_req, 1'b0);
		sw(`ABU_COFF_MASK, 8'h01);
		tv <= 1'b1;
		inw <= 1'b1;
		emu <= 1'b1;
		fe(ma);
		m_act = 1;
		exp_vec.push_back(`ABU_VEC_NORMAL);
		chk(lnk_if.break_req, 1'b1);
		dr(`ABU_OFF_SCR, {1'b1, m_act[0], 6'h00});
		ie;
		chk(lnk_if.watchdog_off, 1'b1);
		chk(16'(n_sint), 16'd1);
		chk(irq, 1'b1);
		sr(`ABU_COFF_STAT, 8'h01);
		sw(`ABU_COFF_STAT, 8'h01);
		st;
		chk(irq, 1'b0);
		dr(`ABU_OFF_WSTAT, 8'h02);
		dw(`ABU_OFF_WSTAT, 8'h00);
		dr(`ABU_OFF_WSTAT, 8'h00);
		for (int i = 0; i < 2; i++) begin
			dw(`ABU_OFF_FCTL, i[0] ? 8'h00 : 8'h80);
			st;
			chk(lnk_if.flag_clear_en, !i[0]);
		end
		ret;
		fe(ma);
		chk(lnk_if.break_req, 1'b0);
		ma = ma ^ 16'h8000;
		dw(`ABU_OFF_ADRH, ma[15:8]);
		sw(`ABU_COFF_CTRL, 8'h04);
		sr(`ABU_COFF_CTRL, 8'h04);
		sw(`ABU_COFF_MASK, 8'h00);
		emu <= 1'b0;
		fe(ma);
		exp_vec.push_back(`ABU_VEC_MONITOR);
		ie;
		chk(irq, 1'b0);
		dr(`ABU_OFF_WSTAT, 8'h00);
		ret;
		dw(`ABU_OFF_SCR, 8'hC0);
		st;
		chk(lnk_if.break_req, 1'b1);
		exp_vec.push_back(`ABU_VEC_NORMAL);
		ie;
		chk(16'(n_sint), 16'd3);
		ret;
		give_verdict;
	end
endmodule // testbench

// File: src/abu_cfg.svh
// Constants for the address breakpoint unit: register offsets, bit positions, reset values.
// Assumes inclusion by bare name from the package and both ends.
`ifndef ABU_CFG_SVH
`define ABU_CFG_SVH

// Device register index on the CPU-side register port
`define ABU_OFF_SCR        3'h0
`define ABU_OFF_ADRH       3'h1
`define ABU_OFF_ADRL       3'h2
`define ABU_OFF_WSTAT      3'h3
`define ABU_OFF_FCTL       3'h4
// Bit positions
`define ABU_BIT_ENABLE     7
`define ABU_BIT_ACTIVE     6
`define ABU_BIT_WAITEXIT   1
`define ABU_BIT_CLRENA     7
// Reset values
`define ABU_RST_BYTE       8'h00
// Break vectors
`define ABU_VEC_NORMAL     16'hFFFC
`define ABU_VEC_MONITOR    16'hFEFC
// Controller register offsets on its software port
`define ABU_COFF_CTRL      2'h0
`define ABU_COFF_STAT      2'h1
`define ABU_COFF_MASK      2'h2
`define ABU_COFF_PC        2'h3
// Controller status/control bits
`define ABU_CBIT_TAKEN     0
`define ABU_CBIT_RET       1
`define ABU_CBIT_MONITOR   2

`endif

// File: src/abu_device.sv
// Address breakpoint unit: breakpoint registers, comparator, break request and break-state controls.
// Assumes the CPU side presents a fetch each cycle with fetch_valid and takes the request at an
// instruction boundary; registers are reached only through the link's own register port.
// A match or a forced break shows on break_req one clock later and holds until the break
// state is seen. Opcode and operand fetches are treated alike here; the CPU side decides
// when the request is taken, which is what separates the two break timings.
`timescale 1ns/1ps
`include "abu_cfg.svh"
module abu_device (
	// Clock, reset, enable
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	input  wire logic clk_en_i,
	// Strap
	input  wire logic emulation_mode_i,
	// Link
	abu_if.device     lnk
);
	// Breakpoint address bytes
	abu_pkg::abu_byte_type adr_h_q;
	abu_pkg::abu_byte_type adr_h_d;
	abu_pkg::abu_byte_type adr_l_q;
	abu_pkg::abu_byte_type adr_l_d;
	// Control and status bits
	logic                  enable_q;
	logic                  enable_d;
	logic                  active_q;
	logic                  active_d;
	logic                  armed_q;
	logic                  armed_d;
	logic                  wexit_q;
	logic                  wexit_d;
	logic                  clrena_q;
	logic                  clrena_d;
	// Registered link outputs
	logic                  req_q;
	logic                  req_d;
	logic                  stop_q;
	logic                  wdog_q;
	logic                  fce_q;
	abu_pkg::abu_byte_type rdata_q;
	abu_pkg::abu_byte_type rdata_d;
	// One equality bit per address bit
	logic [15:0]           bit_eq;

	// Register decode
	function automatic logic hit(input abu_pkg::abu_reg_type a, input abu_pkg::abu_reg_type off);
		hit = (a == off);
	endfunction

	wire logic wr_scr  = lnk.reg_wr && hit(lnk.reg_addr, `ABU_OFF_SCR);
	wire logic wr_h    = lnk.reg_wr && hit(lnk.reg_addr, `ABU_OFF_ADRH);
	wire logic wr_l    = lnk.reg_wr && hit(lnk.reg_addr, `ABU_OFF_ADRL);
	wire logic wr_ws   = lnk.reg_wr && hit(lnk.reg_addr, `ABU_OFF_WSTAT);
	wire logic wr_fc   = lnk.reg_wr && hit(lnk.reg_addr, `ABU_OFF_FCTL);

	// Per-bit comparison against the stored breakpoint; a disabled unit still compares,
	// only the match term below is gated
	wire abu_pkg::abu_addr_type bp_addr = {adr_h_q, adr_l_q};
	for (genvar b = 0; b < 16; b++) begin : g_bit_eq
		assign bit_eq[b] = (lnk.fetch_addr[b] == bp_addr[b]);
	end
	// Comparator runs on every fetch, also in wait, so a match can wake the CPU
	wire logic addr_eq = lnk.fetch_valid && (&bit_eq);
	// Armed is dropped by the first address match; only a write to either address byte re-arms, so a cleared
	// active bit with an unchanged address cannot retrigger
	wire logic match   = enable_q && armed_q && addr_eq;
	wire logic sw_force = wr_scr && lnk.reg_wdata[`ABU_BIT_ACTIVE];

	// Enable gates address matches only; a forced break does not need it
	assign enable_d = wr_scr ? lnk.reg_wdata[`ABU_BIT_ENABLE] : enable_q;
	// Hardware set wins over a software clear in the same cycle
	assign active_d = match || sw_force ? 1'b1 :
	                  (wr_scr ? lnk.reg_wdata[`ABU_BIT_ACTIVE] : active_q);
	// Either address byte re-arms, so a routine that moves the breakpoint gets repeated breaks
	assign armed_d  = (wr_h || wr_l) ? 1'b1 : (match ? 1'b0 : armed_q);
	// Each address byte loads whole from its own index
	assign adr_h_d  = wr_h ? lnk.reg_wdata : adr_h_q;
	assign adr_l_d  = wr_l ? lnk.reg_wdata : adr_l_q;
	// Flag only meaningful in emulation; set wins over a zero write
	assign wexit_d  = !emulation_mode_i ? 1'b0 :
	                  lnk.wait_exit_set ? 1'b1 :
	                  (wr_ws && !lnk.reg_wdata[`ABU_BIT_WAITEXIT]) ? 1'b0 : wexit_q;
	// Only consulted while the break state holds; outside it clears are always allowed
	assign clrena_d = wr_fc ? lnk.reg_wdata[`ABU_BIT_CLRENA] : clrena_q;
	// Request held from match until the CPU enters the break state
	assign req_d    = (match || sw_force) ? 1'b1 : (lnk.break_state ? 1'b0 : req_q);

	// Read mux
	always_comb begin
		rdata_d = `ABU_RST_BYTE;
		case (lnk.reg_addr)
			`ABU_OFF_SCR:   rdata_d = {enable_q, active_q, 6'h00};
			`ABU_OFF_ADRH:  rdata_d = adr_h_q;
			`ABU_OFF_ADRL:  rdata_d = adr_l_q;
			`ABU_OFF_WSTAT: rdata_d = {6'h00, wexit_q, 1'b0};
			`ABU_OFF_FCTL:  rdata_d = {clrena_q, 7'h00};
			default:        rdata_d = `ABU_RST_BYTE;
		endcase
	end

	// Breakpoint address bytes; reset clears both, so the address after reset is zero
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			adr_h_q <= `ABU_RST_BYTE;
			adr_l_q <= `ABU_RST_BYTE;
		end else if (clk_en_i) begin
			adr_h_q <= adr_h_d;
			adr_l_q <= adr_l_d;
		end
	end

	// Enable, active and armed bits; armed resets high so the first match after reset breaks
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			enable_q <= 1'b0;
			active_q <= 1'b0;
			armed_q  <= 1'b1;
		end else if (clk_en_i) begin
			enable_q <= enable_d;
			active_q <= active_d;
			armed_q  <= armed_d;
		end
	end

	// Wait-exit flag and flag-clear enable
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			wexit_q  <= 1'b0;
			clrena_q <= 1'b0;
		end else if (clk_en_i) begin
			wexit_q  <= wexit_d;
			clrena_q <= clrena_d;
		end
	end

	// Break request, held until the CPU side reports the break state
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			req_q <= 1'b0;
		end else if (clk_en_i) begin
			req_q <= req_d;
		end
	end

	// Read data stands for one cycle after a read strobe and is zero otherwise
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rdata_q <= `ABU_RST_BYTE;
		end else if (clk_en_i) begin
			rdata_q <= lnk.reg_rd ? rdata_d : `ABU_RST_BYTE;
		end
	end

	// Timer stop follows the break state one clock late, like every link output
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			stop_q <= 1'b0;
		end else if (clk_en_i) begin
			stop_q <= lnk.break_state;
		end
	end

	// Watchdog disable needs both the break state and the test voltage
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			wdog_q <= 1'b0;
		end else if (clk_en_i) begin
			wdog_q <= lnk.break_state && lnk.test_voltage;
		end
	end

	// Peripheral flags may be cleared freely outside a break; inside one only when enabled.
	// Reads zero during reset, so no clear can slip through before the first clock.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			fce_q <= 1'b0;
		end else if (clk_en_i) begin
			fce_q <= !lnk.break_state || clrena_q;
		end
	end

	// Link outputs, each straight from a flop
	assign lnk.break_req     = req_q;
	assign lnk.reg_rdata     = rdata_q;
	assign lnk.timer_stop    = stop_q;
	assign lnk.watchdog_off  = wdog_q;
	assign lnk.flag_clear_en = fce_q;
endmodule // abu_device

// File: src/abu_host.sv
// CPU / system integration end: takes break requests at instruction boundaries and
// runs the break state until software reports a return from interrupt.
// Assumes the user side presents fetches and instruction boundaries; software drives
// the controller registers over a plain port with read data one cycle later.
`timescale 1ns/1ps
`include "abu_cfg.svh"
module abu_host (
	// Clock, reset, enable
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  clk_en_i,
	// CPU side
	input  wire logic                  fetch_valid_i,
	input  wire abu_pkg::abu_addr_type fetch_addr_i,
	input  wire logic                  opcode_cycle_i,
	input  wire logic                  insn_end_i,
	input  wire logic                  in_wait_i,
	input  wire logic                  test_voltage_i,
	// Device register requests
	input  wire logic                  dev_wr_i,
	input  wire logic                  dev_rd_i,
	input  wire abu_pkg::abu_reg_type  dev_addr_i,
	input  wire abu_pkg::abu_byte_type dev_wdata_i,
	output logic [7:0]                 dev_rdata_o,
	// Controller register port
	input  wire logic [1:0]            sw_addr_i,
	input  wire logic [7:0]            sw_wdata_i,
	input  wire logic                  sw_wr_i,
	input  wire logic                  sw_rd_i,
	output logic [7:0]                 sw_rdata_o,
	// Break outputs
	output logic                       soft_int_load_o,
	output logic [15:0]                vector_o,
	output logic                       irq_o,
	// Link
	abu_if.host                        lnk
);
	typedef enum logic [1:0] {RUN, PEND, BRK} abu_hst_type;
	abu_hst_type st_q, st_d;
	logic [7:0]  stat_q, mask_q, dev_rdata_q, sw_rdata_q;
	logic        mon_q, sint_q, irq_q, wexit_q;
	logic [15:0] vec_q;

	wire logic ctl_wr = sw_wr_i && (sw_addr_i == `ABU_COFF_CTRL);
	wire logic st_wr  = sw_wr_i && (sw_addr_i == `ABU_COFF_STAT);
	wire logic mk_wr  = sw_wr_i && (sw_addr_i == `ABU_COFF_MASK);
	wire logic ret_cmd = ctl_wr && sw_wdata_i[`ABU_CBIT_RET];
	// Break is taken only at an instruction boundary
	wire logic take   = (st_q == PEND) && insn_end_i;
	wire logic [7:0] ev = {7'h00, take};

	// Break state machine
	always_comb begin
		st_d = st_q;
		case (st_q)
			RUN:     if (lnk.break_req) st_d = PEND;
			PEND:    if (insn_end_i) st_d = BRK;
			BRK:     if (ret_cmd) st_d = RUN;
			default: st_d = RUN;
		endcase
	end

	wire logic [7:0] sw_rd_d = (sw_addr_i == `ABU_COFF_CTRL) ? {7'h00, mon_q} << `ABU_CBIT_MONITOR :
	                           (sw_addr_i == `ABU_COFF_STAT) ? stat_q :
	                           (sw_addr_i == `ABU_COFF_MASK) ? mask_q : vec_q[7:0];

	// Controller registers; a new event wins over a write-one clear
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			st_q        <= RUN;
			stat_q      <= 8'h00;
			mask_q      <= 8'h00;
			mon_q       <= 1'b0;
			sint_q      <= 1'b0;
			vec_q       <= `ABU_VEC_NORMAL;
			irq_q       <= 1'b0;
			wexit_q     <= 1'b0;
			dev_rdata_q <= 8'h00;
			sw_rdata_q  <= 8'h00;
		end else if (clk_en_i) begin
			st_q        <= st_d;
			stat_q      <= (stat_q & ~(st_wr ? sw_wdata_i : 8'h00)) | ev;
			mask_q      <= mk_wr ? sw_wdata_i : mask_q;
			mon_q       <= ctl_wr ? sw_wdata_i[`ABU_CBIT_MONITOR] : mon_q;
			sint_q      <= take;
			vec_q       <= mon_q ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
			irq_q       <= |(stat_q & mask_q);
			wexit_q     <= take && in_wait_i;
			dev_rdata_q <= lnk.reg_rdata;
			sw_rdata_q  <= sw_rd_i ? sw_rd_d : 8'h00;
		end
	end

	assign lnk.fetch_valid   = fetch_valid_i;
	assign lnk.fetch_addr    = fetch_addr_i;
	assign lnk.opcode_cycle  = opcode_cycle_i;
	assign lnk.in_wait       = in_wait_i;
	assign lnk.break_state   = (st_q == BRK);
	assign lnk.test_voltage  = test_voltage_i;
	assign lnk.reg_wr        = dev_wr_i;
	assign lnk.reg_rd        = dev_rd_i;
	assign lnk.reg_addr      = dev_addr_i;
	assign lnk.reg_wdata     = dev_wdata_i;
	assign lnk.wait_exit_set = wexit_q;
	assign dev_rdata_o       = dev_rdata_q;
	assign sw_rdata_o        = sw_rdata_q;
	assign soft_int_load_o   = sint_q;
	assign vector_o          = vec_q;
	assign irq_o             = irq_q;
endmodule // abu_host

// File: src/abu_if.sv
// Link between the breakpoint unit and the CPU / system integration side.
// Assumes both ends share sys_clk_i; no tristate pins are involved.
`timescale 1ns/1ps
interface abu_if;
	logic                  fetch_valid;   // CPU fetch cycle of an opcode or operand
	abu_pkg::abu_addr_type fetch_addr;    // Program-counter address
	logic                  opcode_cycle;  // Fetch is of an opcode byte
	logic                  in_wait;       // CPU is in wait mode
	logic                  break_state;   // Break routine is running
	logic                  test_voltage;  // Test high voltage on reset pin
	logic                  reg_wr;
	logic                  reg_rd;
	abu_pkg::abu_reg_type  reg_addr;
	abu_pkg::abu_byte_type reg_wdata;
	abu_pkg::abu_byte_type reg_rdata;
	logic                  break_req;     // Request to take a break
	logic                  timer_stop;    // Halts both timer counters
	logic                  watchdog_off;  // Disables the watchdog
	logic                  flag_clear_en; // Peripheral flags may be cleared
	logic                  wait_exit_set; // Wait was left by a break

	modport device (
		input  fetch_valid, fetch_addr, opcode_cycle, in_wait, break_state, test_voltage,
		input  reg_wr, reg_rd, reg_addr, reg_wdata, wait_exit_set,
		output reg_rdata, break_req, timer_stop, watchdog_off, flag_clear_en
	);
	modport host (
		output fetch_valid, fetch_addr, opcode_cycle, in_wait, break_state, test_voltage,
		output reg_wr, reg_rd, reg_addr, reg_wdata, wait_exit_set,
		input  reg_rdata, break_req, timer_stop, watchdog_off, flag_clear_en
	);
endinterface

// File: src/abu_pkg.sv
// Types shared by both ends of the address breakpoint unit.
// Assumes abu_cfg.svh is on the include path.
`include "abu_cfg.svh"
package abu_pkg;
	typedef logic [7:0]  abu_byte_type;
	typedef logic [15:0] abu_addr_type;
	typedef logic [2:0]  abu_reg_type;
endpackage
